//--- include/pcm_defines.svh
// offsets, ratio ranges, reset values and timing counts for the pll block
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH
`define PCM_OFF_CTRL     12'h000
`define PCM_OFF_BOOST    12'h004
`define PCM_OFF_RATIO    12'h008
`define PCM_OFF_SHIFT    12'h00C
`define PCM_OFF_STATUS   12'h010
`define PCM_OFF_IRQ_STAT 12'h014
`define PCM_OFF_IRQ_MASK 12'h018
`define PCM_CTRL_RST     32'h0000_0000
`define PCM_BOOST_RST    4'h0
`define PCM_M_RST        8'h02
`define PCM_K_RST        8'h02
`define PCM_N_RST        5'h01
`define PCM_V_RST        5'h01
`define PCM_M_MIN        8'h02
`define PCM_M_MAX        8'hA0
`define PCM_N_MIN        5'h01
`define PCM_N_MAX        5'h10
`define PCM_CLK_MHZ      250
`define PCM_TLOCK_US     10
`define PCM_TLOCK_CYC    (`PCM_TLOCK_US * `PCM_CLK_MHZ)
`define PCM_NUM_PLL      4
`endif

//--- include/pcm_pkg.sv
// types shared by the pll clock management block
package pcm_pkg;
  typedef enum logic [3:0] {
    PCM_ST_OFF  = 4'b0001,
    PCM_ST_ACQ  = 4'b0010,
    PCM_ST_LOCK = 4'b0100,
    PCM_ST_LOST = 4'b1000
  } pcm_state_type;
  typedef struct packed {
    logic [7:0] m;
    logic [7:0] k;
    logic [4:0] n;
    logic [4:0] v;
    logic       use_v;
  } pcm_ratio_type;
  typedef struct packed {
    logic [1:0] quad;
    logic [7:0] delay;
    logic       dir_late;
  } pcm_shift_type;
endpackage : pcm_pkg

//--- hdl/pcm_pll_ctrl.sv
// pll lock sequencing, ratio and shift control with apb registers
`timescale 1ns/10ps
`include "pcm_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - clock1 factor never exceeds clock2 factor
// - shared input feeds both sync and multiplier
// - ratio m/(n*k) or m/(n*v), ranges checked
// - phase steps of ninety degrees
// - delay adjust up to one period
// - lock indicator high after acquiring lock
// - lock pin optional, else user io
// - enhanced: ignore reference before configuration done
// - enhanced: acquire immediately after configuration
// - base: lock during configuration
// - base: clocks usable at configuration end
// - up to four independent plls
// - sync output may drive off chip
// - feedback path may go off chip
// - serial plls multiply forwarded clock; this block has no forwarded clock path between plls
module pcm_pll_ctrl
  import pcm_pkg::*;
#(
  parameter int          NUM_PLL    = `PCM_NUM_PLL,
  parameter int          LOCK_CYC   = `PCM_TLOCK_CYC,
  parameter bit          ENHANCED   = 1'b1
)(
  input  wire logic               clk,          // 250 mhz clock
  input  wire logic               rst_n,        // async reset, low
  input  wire logic               cfg_done,     // configuration complete pin
  input  wire logic [NUM_PLL-1:0] ref_ok,       // reference activity pins
  input  wire logic               psel,         // apb select
  input  wire logic               penable,      // apb enable
  input  wire logic               pwrite,       // apb write
  input  wire logic [11:0]        paddr,        // apb byte address
  input  wire logic [31:0]        pwdata,       // apb write data
  output logic      [31:0]        prdata,       // apb read data
  output logic                    pready,       // apb ready
  output logic                    pslverr,      // apb error
  output logic      [NUM_PLL-1:0] lock_o,       // lock pin data
  output logic      [NUM_PLL-1:0] lock_oe_n,    // lock pin enable, low=drive
  output logic      [NUM_PLL-1:0] clk_out_en,   // generated clock gate
  output logic                    ext_out_en,   // off-chip sync output
  output logic                    ext_fb_sel,   // off-chip feedback select
  output logic                    shared_sel,   // shared input mode
  output logic [1:0]              boost1,       // clock1 factor code
  output logic [1:0]              boost2,       // clock2 factor code
  output pcm_ratio_type           ratio,        // active ratio
  output pcm_shift_type           shift,        // active phase/delay
  output logic                    irq           // interrupt level
);
  //////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic               cfg_s1_q;
  logic               cfg_s2_q;
  logic [NUM_PLL-1:0] ref_s1_q;
  logic [NUM_PLL-1:0] ref_s2_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_s1_q <= 1'b0;
      cfg_s2_q <= 1'b0;
      ref_s1_q <= '0;
      ref_s2_q <= '0;
    end
    else
    begin
      cfg_s1_q <= cfg_done;
      cfg_s2_q <= cfg_s1_q;
      ref_s1_q <= ref_ok;
      ref_s2_q <= ref_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]        ctrl_q;
  logic [3:0]         boost_q;
  pcm_ratio_type      ratio_q;
  pcm_shift_type      shift_q;
  logic [7:0]         irq_stat_q;
  logic [7:0]         irq_mask_q;
  logic [7:0]         irq_set;

  // ctrl: [3:0] pll enable, [7:4] lock pin use, 8 ext out, 9 ext fb,
  // 10 shared input
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  wire        acc    = psel & penable;
  wire        wr     = acc & pwrite;
  wire        rd     = acc & ~pwrite;
  wire        h_ctrl = hit(paddr, `PCM_OFF_CTRL);
  wire        h_bst  = hit(paddr, `PCM_OFF_BOOST);
  wire        h_rat  = hit(paddr, `PCM_OFF_RATIO);
  wire        h_sh   = hit(paddr, `PCM_OFF_SHIFT);
  wire        h_st   = hit(paddr, `PCM_OFF_STATUS);
  wire        h_is   = hit(paddr, `PCM_OFF_IRQ_STAT);
  wire        h_im   = hit(paddr, `PCM_OFF_IRQ_MASK);
  wire        mapped = h_ctrl | h_bst | h_rat | h_sh | h_st | h_is | h_im;

  // clock1 factor may not exceed clock2 factor; codes 0=x1 1=x2 2=x4
  wire [1:0]  wb1    = pwdata[1:0];
  wire [1:0]  wb2    = pwdata[3:2];
  wire        bst_ok = (wb2 != 2'd3) && (wb1 <= wb2);
  wire [7:0]  wm     = pwdata[7:0];
  wire [7:0]  wk     = pwdata[15:8];
  wire [4:0]  wn     = pwdata[20:16];
  wire [4:0]  wv     = pwdata[25:21];
  wire        rat_ok = (wm >= `PCM_M_MIN) && (wm <= `PCM_M_MAX)
                    && (wk >= `PCM_M_MIN) && (wk <= `PCM_M_MAX)
                    && (wn >= `PCM_N_MIN) && (wn <= `PCM_N_MAX)
                    && (wv >= `PCM_N_MIN) && (wv <= `PCM_N_MAX);
  wire        bad_wr = wr & ((h_bst & ~bst_ok) | (h_rat & ~rat_ok)
                    | h_st | h_is);

  assign pready  = 1'b1;
  assign pslverr = acc & (~mapped | bad_wr);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q  <= `PCM_CTRL_RST;
      boost_q <= `PCM_BOOST_RST;
      ratio_q <= {`PCM_M_RST, `PCM_K_RST, `PCM_N_RST, `PCM_V_RST, 1'b0};
      shift_q <= '0;
      irq_mask_q <= 8'h00;
    end
    else if (wr)
    begin
      if (h_ctrl)
        ctrl_q <= {21'h0, pwdata[10:0]};
      if (h_bst && bst_ok)
        boost_q <= pwdata[3:0];
      if (h_rat && rat_ok)
        ratio_q <= {wm, wk, wn, wv, pwdata[26]};
      if (h_sh)
        shift_q <= {pwdata[1:0], pwdata[15:8], pwdata[16]};
      if (h_im)
        irq_mask_q <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-pll lock sequencers
  logic [NUM_PLL-1:0] locked;
  logic [NUM_PLL-1:0] lock_ev;
  logic [NUM_PLL-1:0] loss_ev;
  localparam int CW = $clog2(LOCK_CYC + 1);

  genvar g;
  generate
    for (g = 0; g < NUM_PLL; g++)
    begin : g_pll
      pcm_state_type st_q;
      pcm_state_type st_d;
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] cnt_d;
      // base parts lock while configuring; enhanced wait for cfg_done
      wire allowed = ctrl_q[g] & (ENHANCED ? cfg_s2_q : 1'b1);
      wire refg    = ref_s2_q[g];
      always_comb
      begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
          PCM_ST_OFF:
            if (allowed && refg)
            begin
              st_d  = PCM_ST_ACQ;
              cnt_d = '0;
            end
          PCM_ST_ACQ:
            if (!allowed || !refg)
              st_d = allowed ? PCM_ST_LOST : PCM_ST_OFF;
            else if (cnt_q == CW'(LOCK_CYC - 1))
              st_d = PCM_ST_LOCK;
            else
              cnt_d = cnt_q + 1'b1;
          PCM_ST_LOCK:
            if (!allowed)
              st_d = PCM_ST_OFF;
            else if (!refg)
              st_d = PCM_ST_LOST;
          PCM_ST_LOST:
            if (!allowed)
              st_d = PCM_ST_OFF;
            else if (refg)
            begin
              st_d  = PCM_ST_ACQ;
              cnt_d = '0;
            end
          default:
            st_d = PCM_ST_OFF;
        endcase
      end
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          st_q  <= PCM_ST_OFF;
          cnt_q <= '0;
        end
        else
        begin
          st_q  <= st_d;
          cnt_q <= cnt_d;
        end
      end
      assign locked[g]  = (st_q == PCM_ST_LOCK);
      assign lock_ev[g] = (st_d == PCM_ST_LOCK) && (st_q != PCM_ST_LOCK);
      assign loss_ev[g] = (st_d == PCM_ST_LOST) && (st_q == PCM_ST_LOCK);

      a_lock_time: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(locked[g]) |-> $past(st_q == PCM_ST_ACQ))
        else $error("lock asserted without acquisition");
      a_lock_cfg: assert property (@(posedge clk) disable iff (!rst_n)
        (ENHANCED && !cfg_s2_q) |=> !locked[g])
        else $error("lock during configuration");
      a_lock_lost: assert property (@(posedge clk) disable iff (!rst_n)
        (locked[g] && !refg && allowed) |=> !locked[g])
        else $error("lock held after reference loss");

      // a lock never skips any part of the acquisition count
      a_acq_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(locked[g]) |-> $past(cnt_q) == CW'(LOCK_CYC - 1))
        else $error("lock before full acquisition time");
      a_acq_start: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PCM_ST_OFF && allowed && refg)
        |=> (st_q == PCM_ST_ACQ && cnt_q == '0))
        else $error("acquisition did not start at once");
      a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (ENHANCED && !cfg_s2_q) |=> st_q == PCM_ST_OFF)
        else $error("sequencer left off before configuration");
      a_off_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !allowed |=> !locked[g])
        else $error("lock held while pll disabled");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_o     <= '0;
      lock_oe_n  <= '1;
      clk_out_en <= '0;
      ext_out_en <= 1'b0;
      ext_fb_sel <= 1'b0;
      shared_sel <= 1'b0;
      boost1     <= 2'd0;
      boost2     <= 2'd0;
      ratio      <= {`PCM_M_RST, `PCM_K_RST, `PCM_N_RST, `PCM_V_RST, 1'b0};
      shift      <= '0;
    end
    else
    begin
      lock_o     <= locked;
      lock_oe_n  <= ~ctrl_q[NUM_PLL+3:4];
      clk_out_en <= locked;
      ext_out_en <= ctrl_q[8] & locked[0];
      ext_fb_sel <= ctrl_q[9];
      shared_sel <= ctrl_q[10];
      boost1     <= boost_q[1:0];
      boost2     <= boost_q[3:2];
      ratio      <= ratio_q;
      shift      <= shift_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts and read data
  // status has room for four plls; wider builds drop the extra events
  assign irq_set = {4'(loss_ev), 4'(lock_ev)};
  wire rd_is = rd & h_is;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_q <= 8'h00;
    else
      irq_stat_q <= (rd_is ? 8'h00 : irq_stat_q) | irq_set;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  wire [31:0] st_word = {23'h0, cfg_s2_q, {(8-NUM_PLL){1'b0}}, locked};
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd)
    begin
      if (h_ctrl) prdata = ctrl_q;
      if (h_bst)  prdata = {28'h0, boost_q};
      if (h_rat)  prdata = {5'h0, ratio_q.use_v, ratio_q.v, ratio_q.n,
                            ratio_q.k, ratio_q.m};
      if (h_sh)   prdata = {15'h0, shift_q.dir_late, shift_q.delay,
                            6'h0, shift_q.quad};
      if (h_st)   prdata = st_word;
      if (h_is)   prdata = {24'h0, irq_stat_q};
      if (h_im)   prdata = {24'h0, irq_mask_q};
    end
  end

  a_boost_order: assert property (@(posedge clk) disable iff (!rst_n)
    boost_q[1:0] <= boost_q[3:2])
    else $error("clock1 factor above clock2");
  a_ratio_range: assert property (@(posedge clk) disable iff (!rst_n)
    ratio_q.m >= `PCM_M_MIN && ratio_q.m <= `PCM_M_MAX
    && ratio_q.n >= `PCM_N_MIN && ratio_q.n <= `PCM_N_MAX)
    else $error("ratio out of range");
  a_lock_pin: assert property (@(posedge clk) disable iff (!rst_n)
    locked[0] |=> lock_o[0])
    else $error("lock pin not following lock");
  a_irq_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_stat_q[0] && !rd_is) |=> irq_stat_q[0])
    else $error("status bit lost");
  a_ext_out: assert property (@(posedge clk) disable iff (!rst_n)
    ext_out_en |-> $past(locked[0]))
    else $error("off chip clock while unlocked");

  //////////////////////////////////////////////////////////////////////////
  // refused writes must leave the stored value untouched
  a_boost_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && h_bst && !bst_ok) |=> $stable(boost_q))
    else $error("refused boost write was stored");
  a_ratio_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && h_rat && !rat_ok) |=> $stable(ratio_q))
    else $error("refused ratio write was stored");
  a_ratio_kv: assert property (@(posedge clk) disable iff (!rst_n)
    ratio_q.k >= `PCM_M_MIN && ratio_q.k <= `PCM_M_MAX
    && ratio_q.v >= `PCM_N_MIN && ratio_q.v <= `PCM_N_MAX)
    else $error("divider out of range");

  // registered copies trail their source by exactly one edge
  a_lock_oe: assert property (@(posedge clk) disable iff (!rst_n)
    lock_oe_n == ~$past(ctrl_q[NUM_PLL+3:4]))
    else $error("lock pin enable not following control");
  a_ext_fb: assert property (@(posedge clk) disable iff (!rst_n)
    ext_fb_sel == $past(ctrl_q[9]))
    else $error("feedback select not following control");
  a_shared: assert property (@(posedge clk) disable iff (!rst_n)
    shared_sel == $past(ctrl_q[10]))
    else $error("shared input mode not following control");
  a_clk_gate: assert property (@(posedge clk) disable iff (!rst_n)
    clk_out_en == $past(locked))
    else $error("clock gate not following lock");
  a_shift_copy: assert property (@(posedge clk) disable iff (!rst_n)
    shift == $past(shift_q))
    else $error("shift output not following register");
  a_ext_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_q[8] |=> !ext_out_en)
    else $error("off chip clock while not enabled");

  // a new event in the same cycle as a clearing read must survive
  a_stat_set: assert property (@(posedge clk) disable iff (!rst_n)
    irq_set[0] |=> irq_stat_q[0])
    else $error("lock gained event lost");
  a_loss_flag: assert property (@(posedge clk) disable iff (!rst_n)
    loss_ev[0] |=> irq_stat_q[4])
    else $error("lock lost event lost");

  // scenarios worth seeing at least once
  c_lock: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(locked[0]));
  c_loss: cover property (@(posedge clk) disable iff (!rst_n)
    loss_ev[0]);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_refused: cover property (@(posedge clk) disable iff (!rst_n)
    wr && h_bst && !bst_ok);
endmodule : pcm_pll_ctrl

//--- verification/pcm_ref_src.sv
// board clock source model: reference presence per pll
`timescale 1ns/10ps
module pcm_ref_src (
  input  wire logic       clk,    // bench clock
  input  wire logic [3:0] want,   // references that run
  output logic      [3:0] ref_ok  // reference present levels
);
  // a source out of spec is shown as absent, never as half-good
  always @(posedge clk) ref_ok <= want;
endmodule : pcm_ref_src

//--- verification/pcm_pll_ctrl_tb.sv
// self-checking bench for the pll lock, ratio and shift control
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pcm_pll_ctrl_tb
  import pcm_pkg::*;
;
  localparam int LCYC = 16;
  logic clk = 1'b0, rst_n = 1'b0, cfg_done = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, irq, err, bad, ext_out_en, ext_fb_sel, shared_sel;
  logic [3:0] want = 4'h0, ref_ok, lock_o, lock_oe_n, clk_out_en, base_lock;
  logic [3:0] eb;
  logic [1:0] boost1, boost2;
  pcm_ratio_type ratio, exp_ratio;
  pcm_shift_type shift, exp_shift;
  int fail_count = 0, n_checks = 0, cyc = 0, i, m, k, n, v, u;
  int tm[7] = '{1, 2, 160, 161, 2, 2, 2};
  int tn[7] = '{1, 1, 1, 1, 0, 16, 17};

  always #2 clk = ~clk;

  pcm_ref_src u_src (.clk(clk), .want(want), .ref_ok(ref_ok));
  pcm_pll_ctrl #(.NUM_PLL(4), .LOCK_CYC(LCYC), .ENHANCED(1'b1)) u_dut (
    .clk(clk), .rst_n(rst_n), .cfg_done(cfg_done), .ref_ok(ref_ok),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_o(lock_o), .lock_oe_n(lock_oe_n), .clk_out_en(clk_out_en),
    .ext_out_en(ext_out_en), .ext_fb_sel(ext_fb_sel),
    .shared_sel(shared_sel), .boost1(boost1), .boost2(boost2),
    .ratio(ratio), .shift(shift), .irq(irq));
  // base twin sees the same writes; only its lock is watched
  pcm_pll_ctrl #(.NUM_PLL(4), .LOCK_CYC(LCYC), .ENHANCED(1'b0)) u_base (
    .clk(clk), .rst_n(rst_n), .cfg_done(cfg_done), .ref_ok(ref_ok),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .lock_o(base_lock),
    .lock_oe_n(), .clk_out_en(), .ext_out_en(), .ext_fb_sel(),
    .shared_sel(), .boost1(), .boost2(), .ratio(), .shift(), .irq());

//////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // two idle edges: registered outputs have settled when the caller looks
    repeat (2) @(posedge clk);
  endtask : apb

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      summarize();
    end
  end

//////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(76));
    exp_ratio = '{8'h02, 8'h02, 5'h01, 5'h01, 1'b0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(lock_oe_n, 4'hF)
    `CHK(lock_o, 4'h0)
    `CHK(ratio, exp_ratio)
    eb = 4'h0;
    for (i = 0; i < 16; i++)
    begin
      apb(1'b1, 12'h004, 32'(i));
      bad = i[1:0] == 2'd3 || i[3:2] == 2'd3 || i[1:0] > i[3:2];
      `CHK(err, bad)
      if (!bad) eb = i[3:0];
      `CHK({boost2, boost1}, eb)
    end
    // range edges first, then random legal ratios
    for (i = 0; i < 11; i++)
    begin
      m = i < 7 ? tm[i] : 2 + $urandom % 159;
      n = i < 7 ? tn[i] : 1 + $urandom % 16;
      k = i < 7 ? 160 : 2 + $urandom % 159;
      v = i < 7 ? 16 : 1 + $urandom % 16;
      u = $urandom % 2;
      apb(1'b1, 12'h008, {5'h0, u[0], v[4:0], n[4:0], k[7:0], m[7:0]});
      bad = m < 2 || m > 160 || n < 1 || n > 16;
      `CHK(err, bad)
      if (!bad) exp_ratio = '{m[7:0], k[7:0], n[4:0], v[4:0], u[0]};
      `CHK(ratio, exp_ratio)
    end
    for (i = 0; i < 4; i++)
    begin
      exp_shift = '{i[1:0], 8'($urandom), i[0]};
      apb(1'b1, 12'h00C, {15'h0, exp_shift.dir_late, exp_shift.delay,
                          6'h0, exp_shift.quad});
      `CHK(shift, exp_shift)
    end
    apb(1'b1, 12'h018, 32'h0000_000F);
    apb(1'b1, 12'h000, 32'h0000_073F);
    `CHK(lock_oe_n, 4'hC)
    `CHK({shared_sel, ext_fb_sel}, 2'b11)
    want <= 4'hF;
    repeat (40) @(posedge clk);
    `CHK(lock_o, 4'h0)
    `CHK(base_lock, 4'hF)
    cfg_done <= 1'b1;
    i = 0;
    while (lock_o !== 4'hF && i < 40)
    begin
      @(posedge clk);
      i++;
    end
    `CHK(i >= LCYC && i <= LCYC + 6, 1'b1)
    `CHK({ext_out_en, clk_out_en}, 5'h1F)
    `CHK(irq, 1'b1)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(rd, 32'h0000_010F)
    apb(1'b0, 12'h014, 32'h0000_0000);
    `CHK(rd, 32'h0000_000F)
    `CHK(irq, 1'b0)
    want <= 4'h1;
    repeat (6) @(posedge clk);
    `CHK(lock_o, 4'h1)
    `CHK(irq, 1'b0)
    apb(1'b0, 12'h014, 32'h0000_0000);
    `CHK(rd, 32'h0000_00E0)
    apb(1'b1, 12'h010, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h01C, 32'h0000_0000);
    `CHK(err, 1'b1)
    summarize();
  end
endmodule : pcm_pll_ctrl_tb
